// ---- rtl/rtc_pkg.sv ----
// Shared constants and carrier types for the programmable real-time clock.
// Assumes a 100 MHz system clock and a host issuing I/O transfer codes.
package rtc_pkg;

   // ----------------------------------------
   // Widths and timing
   // ----------------------------------------
   localparam int W = 12;              // Counter and word width
   localparam int CLK_NS = 10;         // System clock period
   localparam int T400K_NS = 2500;     // 400 kHz period
   localparam int T100K_NS = 10000;    // 100 kHz period
   localparam int T10K_NS = 100000;    // 10 kHz period
   localparam int T1K_NS = 1000000;    // 1 kHz period
   localparam int T100_NS = 10000000;  // 100 Hz period
   // Cascade ratios, each stage dividing the one before
   localparam int RATE_DIV [5] = '{T400K_NS / CLK_NS, T100K_NS / T400K_NS,
      T10K_NS / T100K_NS, T1K_NS / T10K_NS, T100_NS / T1K_NS};

   // ----------------------------------------
   // Transfer codes
   // ----------------------------------------
   localparam logic [11:0] OP_SKIP = 12'hC59;    // skip_on_irq_cmd
   localparam logic [11:0] OP_CTRL = 12'hC5A;    // control_load_cmd
   localparam logic [11:0] OP_PWR = 12'hC5B;     // preset_write_cmd
   localparam logic [11:0] OP_ENA = 12'hC5C;     // enable_load_cmd
   localparam logic [11:0] OP_STAT = 12'hC5D;    // status_read_clear_cmd
   localparam logic [11:0] OP_PRD = 12'hC5E;     // preset_read_cmd
   localparam logic [11:0] OP_CAP = 12'hC5F;     // counter_capture_read_cmd

   // ----------------------------------------
   // Field positions (word bit 00 is the MSB)
   // ----------------------------------------
   localparam int RATE_HI = 11;        // Count rate field top
   localparam int MODE_HI = 8;         // Mode field top
   localparam int ENA_OR = 7;          // Enable bit 04: OR preset in
   localparam int ENA_OVF = 6;         // Enable bit 05: overflow interrupt
   localparam int ST_OVF = 11;         // Status bit 00: overflow
   localparam int CH_EV0 = 5;          // Channel 1 event / int enable
   localparam int CH_PRE0 = 4;         // Channel 1 pre-event / enable / simulate
   localparam int AD_CH_W = 6;         // A-D channel number width
   localparam logic [2:0] RATE_EXT = 3'h6;       // Count from channel 1
   localparam logic [11:0] RST_WORD = 12'h000;   // Reset of all registers

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic valid;         // One-cycle transfer strobe
      logic [11:0] code;   // io_transfer_instr code
      logic [11:0] ac;     // cpu_work_register value
   } io_req_t;

   typedef struct packed {
      logic ac_we;         // Replace cpu_work_register with ac
      logic skip;          // Skip next instruction
      logic [11:0] ac;     // New cpu_work_register value
   } io_rsp_t;

endpackage : rtc_pkg

// ---- rtl/rate_divider.sv ----
// Cascaded count-rate divider giving one-cycle tick pulses.
// Assumes the system clock; stage ratios come from the package.
`timescale 1ns/1ps
module rate_divider #(
   parameter int STAGES = 5
) (
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   output logic [STAGES-1:0] tick_o
);
   // ----------------------------------------
   // One counter per stage
   // ----------------------------------------
   // Cascading keeps every counter narrow
   logic [STAGES:0] en_w;        // Stage advance enables
   assign en_w[0] = 1'b1;
   genvar g;
   for (g = 0; g < STAGES; g++) begin : g_stage
      logic [7:0] cnt_q;         // Stage position
      logic tick_q;              // Stage output pulse
      wire last_w = (cnt_q == 8'(rtc_pkg::RATE_DIV[g] - 1));
      // Count enabled edges, wrap at the ratio
      always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            cnt_q <= 8'h00;
            tick_q <= 1'b0;
         end else begin
            tick_q <= en_w[g] & last_w;
            if (en_w[g]) begin
               cnt_q <= last_w ? 8'h00 : cnt_q + 8'h01;
            end
         end
      end
      assign en_w[g+1] = tick_q;
      assign tick_o[g] = tick_q;
   end
endmodule : rate_divider

// ---- rtl/edge_sync.sv ----
// Two-flop synchroniser with rising-edge pulse for trigger pins.
// Assumes pins are asynchronous; pulses last at least two clocks.
`timescale 1ns/1ps
module edge_sync #(
   parameter int N = 3
) (
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic [N-1:0] pin_i,
   output logic [N-1:0] rise_o
);
   // ----------------------------------------
   // Synchroniser and edge detect
   // ----------------------------------------
   logic [N-1:0] meta_q;   // First stage, read only by sync_q
   logic [N-1:0] sync_q;   // Safe level
   logic [N-1:0] last_q;   // Previous safe level
   // Shift the pins through three flops
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_q <= '0;
         sync_q <= '0;
         last_q <= '0;
      end else begin
         meta_q <= pin_i;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end
   // One pulse per rising edge
   assign rise_o = sync_q & ~last_q;
endmodule : edge_sync

// ---- rtl/realtime_clock.sv ----
// Programmable real-time clock: counter, preset, mode, enables, status.
// Assumes a host issuing transfer codes as one-cycle strobes, and an
// A-D converter on the same clock taking the overflow trigger.
//
// How it works
// - Mode 000 free-runs, overflow every 4096 counts.
// - Mode 001 reloads counter from preset on overflow.
// - Mode X00 to X01 change zeroes the counter.
// - Mode 010 copies counter into preset per event.
// - Mode 011 also clears counter on event 3.
// - Mode bit 0 overflow triggers A-D when fast-sampling.
// - Low mode bits decode the same with A-D.
// - Sample in mode bit 0 returns last result, latches next channel.
// - Preset write loads preset from work register.
// - Enable load writes enables; bits 00-03 unused.
// - Enable bit 04 ORs preset into counter in X01 with no pending overflow.
// - Enable bits 05,06,08,10 gate interrupts.
// - Enable bits 07,09,11 gate input channels.
// - Status read ORs flags into work register.
// - Status read clears only flags reported set.
// - Status bit layout: 00, 06-11 as listed.
// - Preset read returns preset contents.
// - Capture read copies counter to preset, returns it.
// - Overflow sets when a tick finds the counter at FFF.
// - Rate field picks stop, five rates, channel 1.
// - Control load sets rate, mode, simulated pulses.
// - Skip and interrupt on any enabled flag.
`timescale 1ns/1ps
module realtime_clock #(
   parameter int CH = 3
) (
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input rtc_pkg::io_req_t io_req_i,          // Transfer strobe and word
   output rtc_pkg::io_rsp_t io_rsp_o,         // Registered answer
   input wire logic sample_cmd_i,             // sample_convert_cmd strobe
   input wire logic [11:0] ad_result_i,       // Last A-D conversion
   input wire logic fast_sample_i,            // A-D automatic-sample state
   output logic ad_trigger_o,                 // Start a conversion
   output logic ad_clock_mode_o,              // A-D waits for overflow
   output logic [rtc_pkg::AD_CH_W-1:0] ad_channel_o,
   input wire logic [CH-1:0] ext_input_i,     // Trigger pins
   output logic irq_o                         // Interrupt request
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [11:0] cnt_q, cnt_d;        // Counter
   logic [11:0] preset_q, preset_d;  // Buffer-preset
   logic [2:0] mode_q;               // counting_mode_field
   logic [2:0] rate_q;               // Count rate field
   logic [11:0] en_q;                // clock_enable_bits
   // Status flags stay set until a status read
   logic [11:0] stat_q, stat_d;      // clock_event_status
   logic [rtc_pkg::AD_CH_W-1:0] adch_q;  // Next A-D channel
   logic ad_trig_q;                  // Conversion start pulse
   logic irq_q;                      // Interrupt request level
   rtc_pkg::io_rsp_t rsp_q, rsp_d;   // Answer to the host

   // ----------------------------------------
   // Transfer decode
   // ----------------------------------------
   wire [11:0] ac_w = io_req_i.ac;
   wire hit_w = io_req_i.valid;
   wire op_skip_w = hit_w && io_req_i.code == rtc_pkg::OP_SKIP;
   wire op_ctrl_w = hit_w && io_req_i.code == rtc_pkg::OP_CTRL;
   wire op_pwr_w = hit_w && io_req_i.code == rtc_pkg::OP_PWR;
   wire op_ena_w = hit_w && io_req_i.code == rtc_pkg::OP_ENA;
   wire op_stat_w = hit_w && io_req_i.code == rtc_pkg::OP_STAT;
   wire op_prd_w = hit_w && io_req_i.code == rtc_pkg::OP_PRD;
   wire op_cap_w = hit_w && io_req_i.code == rtc_pkg::OP_CAP;
   // Unknown codes match none of these and get no answer
   // Sample only answered here in clock-triggered mode
   wire op_sample_w = sample_cmd_i && mode_q[2];

   // ----------------------------------------
   // Rate and trigger sources
   // ----------------------------------------
   logic [4:0] div_tick_w;     // 400k, 100k, 10k, 1k, 100 Hz
   logic [CH-1:0] pin_rise_w;  // Synchronised pin edges

   rate_divider #(
      .STAGES(5)
   ) u_div (
      .sys_clk_i(sys_clk_i),
      .arst_n_i(arst_n_i),
      .tick_o(div_tick_w)
   );

   edge_sync #(
      .N(CH)
   ) u_sync (
      .sys_clk_i(sys_clk_i),
      .arst_n_i(arst_n_i),
      .pin_i(ext_input_i),
      .rise_o(pin_rise_w)
   );

   // ----------------------------------------
   // Channel events
   // ----------------------------------------
   // One slice per input channel
   logic [CH-1:0] ev_w;       // Accepted channel pulses
   logic [11:0] set_w;        // Status bits to set this cycle
   genvar g;
   for (g = 0; g < CH; g++) begin : g_ch
      localparam int EV = rtc_pkg::CH_EV0 - 2 * g;
      localparam int PRE = rtc_pkg::CH_PRE0 - 2 * g;
      // Pin edge or simulated pulse, only if channel enabled
      assign ev_w[g] = en_q[PRE] & (pin_rise_w[g] | (op_ctrl_w & ac_w[PRE]));
      // Channel 1 as time base leaves its event flag alone
      wire flag_w = ev_w[g] & !(g == 0 && rate_q == rtc_pkg::RATE_EXT);
      assign set_w[EV] = flag_w;
      // Second event before read marks the pre-event bit
      assign set_w[PRE] = flag_w & stat_q[EV];
   end
   assign set_w[10:6] = '0;

   // ----------------------------------------
   // Count pulse selection
   // ----------------------------------------
   // Codes 000 and 111 stop; rates were synchronised at the source
   wire rate_div_w = rate_q != 3'h0 && rate_q < rtc_pkg::RATE_EXT;
   // Index is only read while rate_div_w holds
   wire [2:0] rate_ix_w = rate_q - 3'h1;
   wire tick_w = rate_div_w ? div_tick_w[rate_ix_w] :
                 (rate_q == rtc_pkg::RATE_EXT) & ev_w[0];

   // ----------------------------------------
   // Counter next value
   // ----------------------------------------
   wire reload_w = mode_q[1:0] == 2'b01;
   wire capmode_w = mode_q[1];
   // OR preset in only in X01 with no pending overflow
   wire or_in_w = op_ena_w & ac_w[rtc_pkg::ENA_OR] & reload_w
                  & !stat_q[rtc_pkg::ST_OVF];
   wire [11:0] base_w = or_in_w ? (cnt_q | preset_q) : cnt_q;
   wire wrap_w = tick_w && base_w == 12'hFFF;
   assign set_w[11] = wrap_w;
   wire [11:0] inc_w = (wrap_w && reload_w) ? preset_q : base_w + 12'h001;
   // X00 to X01 on control load
   wire zero_w = op_ctrl_w && mode_q[1:0] == 2'b00
                 && ac_w[rtc_pkg::MODE_HI-1 -: 2] == 2'b01;
   wire clr3_w = mode_q[1:0] == 2'b11 && ev_w[CH-1];
   wire cap_w = capmode_w && |ev_w;

   // Clears beat a tick; OR-in lands before the tick
   assign cnt_d = (zero_w || clr3_w) ? 12'h000 : tick_w ? inc_w : base_w;

   // ----------------------------------------
   // Preset next value
   // ----------------------------------------
   // Host transfer beats an event capture in the same cycle
   assign preset_d = op_pwr_w ? ac_w :
                     op_cap_w ? cnt_q :
                     cap_w ? cnt_q : preset_q;

   // ----------------------------------------
   // Status next value
   // ----------------------------------------
   // Clear what was reported; a new set in that cycle still lands
   wire [11:0] clr_w = op_stat_w ? stat_q : 12'h000;
   assign stat_d = (stat_q & ~clr_w) | set_w;

   // ----------------------------------------
   // Interrupt condition
   // ----------------------------------------
   // Level follows the flags until a status read clears them
   wire [11:0] ev_mask_w = 12'h02A;                      // Event bits 06,08,10
   wire irq_w = (stat_q[rtc_pkg::ST_OVF] & en_q[rtc_pkg::ENA_OVF])
                | |(stat_q & en_q & ev_mask_w);

   // ----------------------------------------
   // Answer to the host
   // ----------------------------------------
   wire [11:0] rsp_ac_w = op_stat_w ? (ac_w | stat_q) :
                          op_prd_w ? preset_q :
                          op_cap_w ? cnt_q :
                          ad_result_i;
   // Host never issues two answering codes in one cycle
   assign rsp_d.ac_we = op_stat_w | op_prd_w | op_cap_w | op_sample_w;
   assign rsp_d.skip = op_skip_w & irq_w;
   assign rsp_d.ac = rsp_ac_w;

   // ----------------------------------------
   // Counter, preset and status flops
   // ----------------------------------------
   // All state clears at once on reset
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_q <= rtc_pkg::RST_WORD;
         preset_q <= rtc_pkg::RST_WORD;
         stat_q <= rtc_pkg::RST_WORD;
      end else begin
         cnt_q <= cnt_d;
         preset_q <= preset_d;
         stat_q <= stat_d;
      end
   end

   // ----------------------------------------
   // Control and enable flops
   // ----------------------------------------
   // Rate and mode take effect from the next cycle
   // Enable bits 00-03 are stored but steer nothing
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rate_q <= 3'h0;
         mode_q <= 3'h0;
         en_q <= rtc_pkg::RST_WORD;
      end else begin
         if (op_ctrl_w) begin
            rate_q <= ac_w[rtc_pkg::RATE_HI -: 3];
            mode_q <= ac_w[rtc_pkg::MODE_HI -: 3];
         end
         if (op_ena_w) begin
            en_q <= ac_w;
         end
      end
   end

   // ----------------------------------------
   // A-D link and answer flops
   // ----------------------------------------
   // Trigger only on overflow in clock-triggered mode
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ad_trig_q <= 1'b0;
         adch_q <= '0;
         irq_q <= 1'b0;
         rsp_q <= '0;
      end else begin
         ad_trig_q <= mode_q[2] & wrap_w & fast_sample_i;
         if (op_sample_w) begin
            adch_q <= ac_w[rtc_pkg::AD_CH_W-1:0];
         end
         irq_q <= irq_w;
         rsp_q <= rsp_d;
      end
   end

   // Every output comes straight from a flop
   assign ad_trigger_o = ad_trig_q;
   assign ad_clock_mode_o = mode_q[2];
   assign ad_channel_o = adch_q;
   assign irq_o = irq_q;
   assign io_rsp_o = rsp_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!arst_n_i);

   ovf_flag_set_a: assert property (
      wrap_w |=> stat_q[rtc_pkg::ST_OVF])
      else $error("overflow flag not set on wrap");

   preset_reload_a: assert property (
      wrap_w && reload_w && !zero_w |=> cnt_q == $past(preset_q))
      else $error("counter not reloaded from preset");

   mode_zero_a: assert property (
      zero_w |=> cnt_q == 12'h000)
      else $error("counter not zeroed on mode change");

   event_capture_a: assert property (
      cap_w && !op_pwr_w && !op_cap_w |=> preset_q == $past(cnt_q))
      else $error("event did not capture counter");

   event3_clear_a: assert property (
      clr3_w && !op_pwr_w |=> cnt_q == 12'h000 && preset_q == $past(cnt_q))
      else $error("event 3 capture and clear wrong");

   ad_trigger_a: assert property (
      ad_trigger_o |-> $past(mode_q[2] && wrap_w && fast_sample_i))
      else $error("A-D trigger without overflow");

   preset_write_a: assert property (
      op_pwr_w |=> preset_q == $past(ac_w) && !io_rsp_o.ac_we)
      else $error("preset write wrong");

   status_read_a: assert property (
      op_stat_w |=> io_rsp_o.ac_we && io_rsp_o.ac == $past(ac_w | stat_q))
      else $error("status read value wrong");

   status_clear_a: assert property (
      op_stat_w && set_w == 12'h000 |=> stat_q == 12'h000)
      else $error("status not cleared after read");

   capture_read_a: assert property (
      op_cap_w && !op_pwr_w |=> preset_q == $past(cnt_q) && io_rsp_o.ac == $past(cnt_q))
      else $error("capture read wrong");

   // ----------------------------------------
   // Checks on transfers and counting
   // ----------------------------------------
   // Sample returns the last result and latches the channel
   sample_answer_a: assert property (
      op_sample_w && !op_stat_w && !op_prd_w && !op_cap_w |=> io_rsp_o.ac_we
         && io_rsp_o.ac == $past(ad_result_i)
         && ad_channel_o == $past(ac_w[rtc_pkg::AD_CH_W-1:0]))
      else $error("sample answer or channel wrong");

   // Preset read answers with the preset
   preset_read_a: assert property (
      op_prd_w && !op_stat_w |=> io_rsp_o.ac_we && io_rsp_o.ac == $past(preset_q))
      else $error("preset read wrong");

   // Enable load takes the whole word
   enable_load_a: assert property (
      op_ena_w |=> en_q == $past(ac_w))
      else $error("enable load wrong");

   // Control load takes rate and mode fields
   control_load_a: assert property (
      op_ctrl_w |=> rate_q == $past(ac_w[rtc_pkg::RATE_HI -: 3])
         && mode_q == $past(ac_w[rtc_pkg::MODE_HI -: 3]))
      else $error("control load wrong");

   // OR-in with no tick leaves counter OR preset
   preset_or_in_a: assert property (
      or_in_w && !zero_w && !clr3_w && !tick_w |=> cnt_q == $past(cnt_q | preset_q))
      else $error("preset not ORed into counter");

   // Enabled channel 1 pulse sets its event flag
   event_flag_a: assert property (
      ev_w[0] && rate_q != rtc_pkg::RATE_EXT |=> stat_q[rtc_pkg::CH_EV0])
      else $error("channel 1 event flag not set");

   // Channel 1 as time base counts one per pulse
   time_base_a: assert property (
      rate_q == rtc_pkg::RATE_EXT && ev_w[0] && mode_q[1:0] == 2'b00 && !zero_w
         && cnt_q != 12'hFFF |=> cnt_q == $past(cnt_q) + 12'h001)
      else $error("time base pulse not counted");

   // Stop codes hold the counter still
   count_stop_a: assert property (
      (rate_q == 3'h0 || rate_q == 3'h7) && !op_ena_w && !op_ctrl_w && !ev_w[CH-1]
         |=> cnt_q == $past(cnt_q))
      else $error("counter moved while stopped");

   skip_irq_a: assert property (
      op_skip_w |=> io_rsp_o.skip == $past(irq_w) && irq_o == $past(irq_w))
      else $error("skip or interrupt disagrees");

endmodule : realtime_clock

// ---- verif/host_model.sv ----
// Host and A-D converter model facing the real-time clock block.
// Assumes requests are taken on the rising edge of sys_clk_i.
`timescale 1ns/1ps
module host_model (
   input wire logic sys_clk_i,
   output rtc_pkg::io_req_t io_req_o,
   input rtc_pkg::io_rsp_t io_rsp_i,
   output logic sample_cmd_o,
   output logic [11:0] ad_result_o,
   output logic fast_sample_o,
   input wire logic ad_trigger_i
);
   // ----------------------------------------
   // Model state
   // ----------------------------------------
   rtc_pkg::io_req_t req_q = '0;     // Transfer lines, strobe idle low
   logic samp_q = 1'b0;              // Sample strobe
   logic fast_q = 1'b0;              // Automatic-sample state, set by bench
   logic [11:0] result_q = 12'h5A0;  // Last completed conversion

   assign io_req_o = req_q;
   assign sample_cmd_o = samp_q;
   assign ad_result_o = result_q;
   assign fast_sample_o = fast_q;

   // ----------------------------------------
   // Converter
   // ----------------------------------------
   // Each overflow trigger completes one new conversion
   always @(posedge sys_clk_i) begin
      if (ad_trigger_i === 1'b1) begin
         result_q <= result_q + 12'h001;
      end
   end

   // ----------------------------------------
   // Transfer: raise after a falling edge, hold over the taking edge
   // ----------------------------------------
   // Answer is read one cycle later, while it stands settled
   task automatic issue(input logic smp, input logic [11:0] code,
      input logic [11:0] ac, output rtc_pkg::io_rsp_t rsp);
      @(negedge sys_clk_i);
      req_q.code = code;
      req_q.ac = ac;
      if (smp) begin
         samp_q = 1'b1;
      end else begin
         req_q.valid = 1'b1;
      end
      @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      rsp = io_rsp_i;
      req_q.valid = 1'b0;
      samp_q = 1'b0;
      // Released lines show junk, not the last word
      req_q.code = ~code;
      req_q.ac = ~ac;
   endtask : issue
endmodule : host_model

// ---- verif/testbench.sv ----
// Self-checking bench for the real-time clock block.
// Assumes host_model plays the host and the A-D converter.
`timescale 1ns/1ps
`define CHK(what, exp, got) \
   begin \
      total_checks++; \
      if ((got) !== (exp)) begin \
         num_errors++; \
         $display("ERROR %s expected %h seen %h", what, exp, got); \
      end \
   end
module testbench;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [2:0] ext_pins = 3'h0;      // Trigger pins, index 0 is channel 1
   int num_errors = 0;
   int total_checks = 0;
   rtc_pkg::io_req_t io_req;
   rtc_pkg::io_rsp_t io_rsp;
   rtc_pkg::io_rsp_t rsp;            // Answer to the last transfer
   logic sample_cmd, fast_sample, ad_trigger, ad_clock_mode, irq;
   logic [11:0] ad_result;
   logic [5:0] ad_channel;

   always #5 sys_clk = ~sys_clk;

   realtime_clock realtime_clock_i (
      .sys_clk_i(sys_clk), .arst_n_i(arst_n), .io_req_i(io_req), .io_rsp_o(io_rsp),
      .sample_cmd_i(sample_cmd), .ad_result_i(ad_result), .fast_sample_i(fast_sample),
      .ad_trigger_o(ad_trigger), .ad_clock_mode_o(ad_clock_mode),
      .ad_channel_o(ad_channel), .ext_input_i(ext_pins), .irq_o(irq));

   host_model host_model_i (
      .sys_clk_i(sys_clk), .io_req_o(io_req), .io_rsp_i(io_rsp),
      .sample_cmd_o(sample_cmd), .ad_result_o(ad_result),
      .fast_sample_o(fast_sample), .ad_trigger_i(ad_trigger));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic io(input logic [11:0] code, input logic [11:0] ac);
      host_model_i.issue(1'b0, code, ac, rsp);
   endtask : io

   // Pin pulse long enough for the synchroniser, then settle time
   task automatic pulse(input int idx);
      @(negedge sys_clk);
      ext_pins[idx] = 1'b1;
      repeat (3) @(negedge sys_clk);
      ext_pins[idx] = 1'b0;
      repeat (6) @(negedge sys_clk);
   endtask : pulse

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic test_preset();
      io(rtc_pkg::OP_PRD, 12'hABC);
      `CHK("preset at reset", 13'h1000, {rsp.ac_we, rsp.ac})
      io(rtc_pkg::OP_PWR, 12'h5A3);
      `CHK("preset write answer", 1'b0, rsp.ac_we)
      io(12'hC58, 12'h000);
      `CHK("unknown code answer", 1'b0, rsp.ac_we)
      io(rtc_pkg::OP_PRD, 12'hFFF);
      `CHK("preset read", 13'h15A3, {rsp.ac_we, rsp.ac})
      $display("test_preset done");
   endtask : test_preset

   task automatic test_reload();
      int n;
      io(rtc_pkg::OP_PWR, 12'hFFE);
      io(rtc_pkg::OP_CTRL, 12'h040);     // Mode 001, stopped
      io(rtc_pkg::OP_ENA, 12'h0C0);      // OR-in and overflow interrupt
      io(rtc_pkg::OP_CAP, 12'h000);
      `CHK("or-in capture", 12'hFFE, rsp.ac)
      io(rtc_pkg::OP_CTRL, 12'h240);     // Count at 400 kHz
      n = 0;
      do begin
         io(rtc_pkg::OP_SKIP, 12'h000);
         n++;
      end while (rsp.skip !== 1'b1 && n < 600);
      `CHK("skip on overflow", 1'b1, rsp.skip)
      if (n >= 600) begin
         give_verdict();
      end
      io(rtc_pkg::OP_CTRL, 12'h040);     // Stop before the next tick
      `CHK("overflow irq", 1'b1, irq)
      io(rtc_pkg::OP_CAP, 12'h000);
      `CHK("reload from preset", 12'hFFE, rsp.ac)
      io(rtc_pkg::OP_STAT, 12'h00F);
      `CHK("status or", 12'h80F, rsp.ac)
      io(rtc_pkg::OP_STAT, 12'h000);
      `CHK("status cleared", 12'h000, rsp.ac)
      `CHK("irq cleared", 1'b0, irq)
      $display("test_reload done");
   endtask : test_reload

   task automatic test_events();
      io(rtc_pkg::OP_CTRL, 12'h080);     // Mode 010, stopped
      io(rtc_pkg::OP_ENA, 12'h031);      // Channels 1, 3; event 1 irq
      pulse(1);
      io(rtc_pkg::OP_STAT, 12'h000);
      `CHK("disabled channel", 12'h000, rsp.ac)
      io(rtc_pkg::OP_PWR, 12'h123);
      pulse(0);
      `CHK("event irq", 1'b1, irq)
      io(rtc_pkg::OP_PRD, 12'h000);
      `CHK("event capture", 12'hFFE, rsp.ac)
      io(rtc_pkg::OP_CTRL, 12'h090);     // Simulated channel 1 pulse
      repeat (4) @(negedge sys_clk);
      io(rtc_pkg::OP_STAT, 12'h000);
      `CHK("event and pre-event", 12'h030, rsp.ac)
      io(rtc_pkg::OP_CTRL, 12'h0C0);     // Mode 011
      io(rtc_pkg::OP_PWR, 12'h123);
      pulse(0);
      io(rtc_pkg::OP_CAP, 12'h000);
      `CHK("event 1 keeps count", 12'hFFE, rsp.ac)
      io(rtc_pkg::OP_PWR, 12'h123);
      pulse(2);
      io(rtc_pkg::OP_PRD, 12'h000);
      `CHK("event 3 capture", 12'hFFE, rsp.ac)
      io(rtc_pkg::OP_CAP, 12'h000);
      `CHK("event 3 clear", 12'h000, rsp.ac)
      io(rtc_pkg::OP_STAT, 12'h000);
      `CHK("events 1 and 3", 12'h022, rsp.ac)
      io(rtc_pkg::OP_CTRL, 12'hC10);     // Rate 110, mode 000, pulse at old rate
      io(rtc_pkg::OP_CTRL, 12'hC10);     // Pulse now counts as time base
      io(rtc_pkg::OP_STAT, 12'h000);
      `CHK("time base flag", 12'h020, rsp.ac)
      io(rtc_pkg::OP_CAP, 12'h000);
      `CHK("time base count", 12'h001, rsp.ac)
      $display("test_events done");
   endtask : test_events

   task automatic test_adc();
      int n;
      host_model_i.fast_q = 1'b1;
      io(rtc_pkg::OP_PWR, 12'hFFF);
      io(rtc_pkg::OP_CTRL, 12'h100);     // Mode 100, stopped
      io(rtc_pkg::OP_CTRL, 12'h140);     // Mode 101
      io(rtc_pkg::OP_ENA, 12'h080);      // Counter becomes FFF
      `CHK("clock mode", 1'b1, ad_clock_mode)
      io(rtc_pkg::OP_CTRL, 12'h340);
      n = 0;
      while (ad_trigger !== 1'b1 && n < 600) begin
         @(negedge sys_clk);
         n++;
      end
      `CHK("overflow trigger", 1'b1, ad_trigger)
      if (n >= 600) begin
         give_verdict();
      end
      io(rtc_pkg::OP_CTRL, 12'h100);
      io(rtc_pkg::OP_CAP, 12'h000);
      `CHK("reload with bit 0", 12'hFFF, rsp.ac)
      host_model_i.issue(1'b1, 12'h000, 12'h02A, rsp);
      `CHK("sample result", 13'h15A1, {rsp.ac_we, rsp.ac})
      `CHK("next channel", 6'h2A, ad_channel)
      io(rtc_pkg::OP_CTRL, 12'h140);     // X00 to X01
      io(rtc_pkg::OP_CAP, 12'h000);
      `CHK("mode change zero", 12'h000, rsp.ac)
      $display("test_adc done");
   endtask : test_adc

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (6) @(negedge sys_clk);
      arst_n = 1'b1;
      test_preset();
      test_reload();
      test_events();
      test_adc();
      give_verdict();
   end
endmodule : testbench
